// >>> design/flow_through_burst_sram_map.vh
// constants for the flow-through burst sram block
// assumes one 250 MHz clock and synchronous inputs
`ifndef FLOW_THROUGH_BURST_SRAM_MAP_VH
`define FLOW_THROUGH_BURST_SRAM_MAP_VH
`define SRAM_ADDR_WIDTH        18
`define SRAM_LANES             4
`define SRAM_LANE_BITS         9
`define SRAM_BURST_LEN         4
`define SRAM_CLK_PERIOD_PS     4000
`define SRAM_DATA_VALID_PS     7500
`define SRAM_SLEEP_CYCLES      2
`define SRAM_ST_AWAKE          2'h0
`define SRAM_ST_ENTER          2'h1
`define SRAM_ST_ASLEEP         2'h2
`define SRAM_ST_EXIT           2'h3
`endif

// >>> design/sram_word_buffer.v
// two-entry valid/ready buffer for read words
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module sram_word_buffer #(
    parameter WIDTH = 36
) (
    // clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // filling side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // draining side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] slot [0:1];
    reg             rdPtr;
    reg             wrPtr;
    reg [1:0]       count;
    wire            push = inValid && (count != 2'h2);
    wire            pop  = outReady && (count != 2'h0);
    assign inReady  = (count != 2'h2);
    assign outValid = (count != 2'h0);
    assign outData  = slot[rdPtr];
    always @(posedge clk) begin
        if (sys_rst) begin
            rdPtr <= 1'b0;
            wrPtr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                slot[wrPtr] <= inData;
                wrPtr       <= ~wrPtr;
            end
            if (pop)
                rdPtr <= ~rdPtr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end
endmodule // sram_word_buffer
`default_nettype wire

// >>> design/flow_through_burst_sram.v
// flow-through burst sram access logic with internal array
// assumes synchronous pins; bus wire resolved outside from the enable
`timescale 1ns/1ps
`include "flow_through_burst_sram_map.vh"
`default_nettype none
module flow_through_burst_sram #(
    parameter ADDR_WIDTH = `SRAM_ADDR_WIDTH,
    parameter LANES      = `SRAM_LANES,
    parameter LANE_BITS  = `SRAM_LANE_BITS
) (
    // clock and reset
    input  wire                        clk,
    input  wire                        sys_rst,
    // command pins
    input  wire                        clock_qualify_n,
    input  wire                        chip_select_one_n,
    input  wire                        chip_select_two,
    input  wire                        chip_select_three_n,
    input  wire                        burst_step_or_load_n,
    input  wire                        writeEnable_n,
    input  wire [LANES-1:0]            byte_lane_write_n,
    input  wire [ADDR_WIDTH-1:0]       address,
    input  wire                        outputEnable_n,
    input  wire                        burstOrder,
    input  wire                        sleep_request,
    // shared data bus, parity bit is top of each lane
    input  wire [LANES*LANE_BITS-1:0]  dataIn,
    output reg  [LANES*LANE_BITS-1:0]  dataOut,
    output reg                         dataOe_n,
    // read word stream
    output reg                         readValid,
    input  wire                        readReady,
    output reg  [LANES*LANE_BITS-1:0]  readWord,
    // status
    output reg                         asleep,
    output reg                         readStall
);
    localparam WIDTH = LANES * LANE_BITS;
    localparam DEPTH = 1 << ADDR_WIDTH;
    localparam [1:0] ST_AWAKE  = `SRAM_ST_AWAKE;
    localparam [1:0] ST_ENTER  = `SRAM_ST_ENTER;
    localparam [1:0] ST_ASLEEP = `SRAM_ST_ASLEEP;
    localparam [1:0] ST_EXIT   = `SRAM_ST_EXIT;
    localparam integer SLEEP_LAST_I = `SRAM_SLEEP_CYCLES - 1;
    localparam [1:0]   SLEEP_LAST   = SLEEP_LAST_I[1:0];
    localparam integer BEAT_LAST_I  = `SRAM_BURST_LEN - 1;
    localparam [1:0]   BEAT_LAST    = BEAT_LAST_I[1:0];

    reg  [WIDTH-1:0]      mem [0:DEPTH-1];
    reg  [ADDR_WIDTH-1:0] baseAddr;
    reg  [1:0]            beat;
    reg                   burstWrite;
    reg                   active;
    reg                   wasDeselected;
    reg                   wrPending;
    reg  [ADDR_WIDTH-1:0] wrAddr;
    reg  [1:0]            sleepState;
    reg  [1:0]            sleepCount;
    reg                   sleepSync;
    wire                  bufInReady;
    wire                  bufOutValid;
    wire [WIDTH-1:0]      bufOutData;
    wire                  awake     = (sleepState == ST_AWAKE);
    wire                  qualified = !clock_qualify_n && awake;
    wire                  selected  = !chip_select_one_n && chip_select_two &&
                                      !chip_select_three_n;
    wire                  loadCycle = !burst_step_or_load_n;
    wire                  stepCycle = burst_step_or_load_n && active;
    wire                  startRead = qualified && loadCycle && selected &&
                                      writeEnable_n;
    wire                  startWrite = qualified && loadCycle && selected &&
                                       !writeEnable_n;
    wire [1:0]            nextBeat  = beat + 2'h1;
    reg  [1:0]            lowBits;
    reg  [ADDR_WIDTH-1:0] accessAddr;
    reg                   readNow;
    reg                   writeNow;
    reg  [WIDTH-1:0]      mergedWord;
    integer               i;

    // burst beat address from the strap and start bits
    always @* begin
        lowBits    = 2'h0;
        accessAddr = address;
        readNow    = 1'b0;
        writeNow   = 1'b0;
        if (burstOrder)
            lowBits = baseAddr[1:0] ^ nextBeat;
        else
            lowBits = baseAddr[1:0] + nextBeat;
        if (startRead) begin
            accessAddr = address;
            readNow    = 1'b1;
        end else if (qualified && stepCycle && nextBeat <= BEAT_LAST && beat != BEAT_LAST) begin
            accessAddr = {baseAddr[ADDR_WIDTH-1:2], lowBits};
            readNow    = !burstWrite;
            writeNow   = burstWrite;
        end
        if (startWrite)
            writeNow = 1'b1;
    end

    // byte lane merge for the pending write
    always @* begin
        mergedWord = mem[wrAddr];
        for (i = 0; i < LANES; i = i + 1) begin
            if (!byte_lane_write_n[i])
                mergedWord[i*LANE_BITS +: LANE_BITS] = dataIn[i*LANE_BITS +: LANE_BITS];
        end
    end

    // sleep request taken through one flop, one cycle in ST_ENTER and one in ST_EXIT
    always @(posedge clk) begin
        if (sys_rst) begin
            sleepSync  <= 1'b0;
            sleepState <= ST_AWAKE;
            sleepCount <= 2'h0;
            asleep     <= 1'b0;
        end else begin
            sleepSync <= sleep_request;
            case (sleepState)
                ST_AWAKE: begin
                    sleepCount <= 2'h0;
                    if (sleepSync)
                        sleepState <= ST_ENTER;
                end
                ST_ENTER: begin
                    sleepCount <= sleepCount + 2'h1;
                    if (sleepCount == SLEEP_LAST - 2'h1) begin
                        sleepState <= ST_ASLEEP;
                        asleep     <= 1'b1;
                    end
                end
                ST_ASLEEP: begin
                    sleepCount <= 2'h0;
                    if (!sleepSync)
                        sleepState <= ST_EXIT;
                end
                ST_EXIT: begin
                    sleepCount <= sleepCount + 2'h1;
                    if (sleepCount == SLEEP_LAST - 2'h1) begin
                        sleepState <= ST_AWAKE;
                        asleep     <= 1'b0;
                    end
                end
                default: sleepState <= ST_AWAKE;
            endcase
        end
    end

    // command pipeline, burst counter and write completion
    always @(posedge clk) begin
        if (sys_rst) begin
            baseAddr      <= {ADDR_WIDTH{1'b0}};
            beat          <= 2'h0;
            burstWrite    <= 1'b0;
            active        <= 1'b0;
            wasDeselected <= 1'b1;
            wrPending     <= 1'b0;
            wrAddr        <= {ADDR_WIDTH{1'b0}};
            dataOut       <= {WIDTH{1'b0}};
            dataOe_n      <= 1'b1;
        end else if (!awake) begin
            active        <= 1'b0;
            wrPending     <= 1'b0;
            wasDeselected <= 1'b1;
            dataOe_n      <= 1'b1;
        end else if (qualified) begin
            if (wrPending)
                mem[wrAddr] <= mergedWord;
            wrPending <= writeNow;
            if (writeNow)
                wrAddr <= accessAddr;
            if (readNow)
                dataOut <= mem[accessAddr];
            if (loadCycle) begin
                if (selected) begin
                    baseAddr   <= address;
                    beat       <= 2'h0;
                    burstWrite <= !writeEnable_n;
                    active     <= 1'b1;
                end else begin
                    active <= 1'b0;
                end
                wasDeselected <= !selected;
            end else if (stepCycle && beat != BEAT_LAST) begin
                beat <= nextBeat;
            end else begin
                active <= 1'b0;
            end
            // drive only for an output-enabled read beat that does not follow a deselect load
            dataOe_n <= !(readNow && !outputEnable_n && !writeNow &&
                          !wasDeselected);
        end
    end

    // read words also offered as a stream with back-pressure
    sram_word_buffer #(
        .WIDTH(WIDTH)
    ) readBuffer (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .inValid  (qualified && readNow),
        .inReady  (bufInReady),
        .inData   (mem[accessAddr]),
        .outValid (bufOutValid),
        .outReady (!readValid || readReady),
        .outData  (bufOutData)
    );

    always @(posedge clk) begin
        if (sys_rst) begin
            readValid <= 1'b0;
            readWord  <= {WIDTH{1'b0}};
            readStall <= 1'b0;
        end else begin
            readStall <= !bufInReady;
            if (!readValid || readReady) begin
                readValid <= bufOutValid;
                readWord  <= bufOutData;
            end
        end
    end
endmodule // flow_through_burst_sram
`default_nettype wire

// >>> testbench/flow_through_burst_sram_properties.sv
// checker for the burst sram access block
// bound to the top module, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module flow_through_burst_sram_properties #(
    parameter LANES     = 4,
    parameter LANE_BITS = 9
) (
    input wire                         clk,
    input wire                         sys_rst,
    input wire                         clock_qualify_n,
    input wire                         chip_select_one_n,
    input wire                         chip_select_two,
    input wire                         chip_select_three_n,
    input wire                         burst_step_or_load_n,
    input wire                         writeEnable_n,
    input wire                         outputEnable_n,
    input wire                         sleep_request,
    input wire [LANES*LANE_BITS-1:0]   dataOut,
    input wire                         dataOe_n,
    input wire                         readValid,
    input wire                         asleep
);
    wire q   = !clock_qualify_n && !asleep;
    wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
    wire ld  = q && !burst_step_or_load_n;
    wire rdT = ld && sel && writeEnable_n;
    wire wrT = ld && sel && !writeEnable_n;
    wire dsT = ld && !sel;
    wire oe  = !outputEnable_n;

    AST_FREEZE: assert property (@(posedge clk) disable iff (sys_rst)
        clock_qualify_n |=> $stable(dataOut) && $stable(dataOe_n)) else $error("edge not ignored");
    AST_WRFLOAT: assert property (@(posedge clk) disable iff (sys_rst)
        wrT |=> dataOe_n) else $error("bus driven in write");
    AST_DESEL: assert property (@(posedge clk) disable iff (sys_rst)
        dsT |=> dataOe_n) else $error("bus driven when deselected");
    AST_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
        dsT ##1 rdT |=> dataOe_n) else $error("first read drove bus");
    AST_OEGATE: assert property (@(posedge clk) disable iff (sys_rst)
        rdT && !oe ##1 q && !oe |-> ##1 dataOe_n) else $error("drive without enable");
    AST_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
        rdT && oe ##1 q && burst_step_or_load_n && oe |=> !dataOe_n)
        else $error("burst read not driven");
    AST_SLEEPIN: assert property (@(posedge clk) disable iff (sys_rst)
        sleep_request [*8] |-> asleep) else $error("sleep not entered");
    AST_SLEEPOUT: assert property (@(posedge clk) disable iff (sys_rst)
        !sleep_request [*8] |-> !asleep) else $error("sleep not left");
    AST_PWRUP: assert property (@(posedge clk)
        sys_rst |=> dataOe_n && !readValid) else $error("not idle after reset");
endmodule // flow_through_burst_sram_properties

bind flow_through_burst_sram flow_through_burst_sram_properties #(
    .LANES(LANES), .LANE_BITS(LANE_BITS)) u_props (.*);
`default_nettype wire

// >>> testbench/host_bus_model.sv
// host side of the shared data bus: resolves the wire level
// assumes the device enable is low while it drives
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input  wire        clk,
    input  wire [35:0] devData,
    input  wire        devOe_n,
    input  wire [35:0] hostData,
    input  wire        hostDrive,
    output wire [35:0] busLevel,
    output wire        clash
);
    reg [35:0] lastLvl = 36'h0;
    // floating bus keeps changing
    assign busLevel = hostDrive ? hostData : (!devOe_n ? devData : ~lastLvl);
    assign clash    = hostDrive && !devOe_n;
    always @(posedge clk) begin
        lastLvl <= busLevel;
    end
endmodule // host_bus_model
`default_nettype wire

// >>> testbench/flow_through_burst_sram_bench.sv
// bench for the burst sram block: bursts, lanes, freeze, stream, sleep
// assumes design, checker and host bus model compiled first
`timescale 1ns/1ps
`default_nettype none
module flow_through_burst_sram_bench;
    reg         clk = 1'b0, sys_rst = 1'b1, qualN = 1'b0, sel = 1'b0;
    reg         loadN = 1'b0, wrN = 1'b1, oeN = 1'b0, order = 1'b0;
    reg         sleepReq = 1'b0, rdy = 1'b1, hostDrive = 1'b0;
    reg  [3:0]  laneN = 4'h0;
    reg  [17:0] addr = 18'h0;
    reg  [35:0] hostData = 36'h0;
    reg  [35:0] mem [0:255];
    wire [35:0] dOut, rWord, bus;
    wire        dOeN, rValid, slp, clash, stall;
    integer     errorCnt = 0, compares = 0, cycles = 0;

    flow_through_burst_sram u_flow_through_burst_sram (.clk(clk), .sys_rst(sys_rst),
        .clock_qualify_n(qualN), .chip_select_one_n(!sel), .chip_select_two(sel),
        .chip_select_three_n(!sel), .burst_step_or_load_n(loadN), .writeEnable_n(wrN),
        .byte_lane_write_n(laneN), .address(addr), .outputEnable_n(oeN),
        .burstOrder(order), .sleep_request(sleepReq), .dataIn(bus), .dataOut(dOut),
        .dataOe_n(dOeN), .readValid(rValid), .readReady(rdy), .readWord(rWord),
        .asleep(slp), .readStall(stall));
    host_bus_model u_host_bus_model (.clk(clk), .devData(dOut), .devOe_n(dOeN),
        .hostData(hostData), .hostDrive(hostDrive), .busLevel(bus), .clash(clash));

    initial begin
        forever #2 clk = ~clk;
    end

    task close_out;
        begin
            if (errorCnt == 0 && compares > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task automatic check(input [35:0] got, input [35:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                errorCnt = errorCnt + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    function [17:0] bAddr(input [17:0] a, input integer j);
        bAddr = {a[17:2], order ? a[1:0] ^ j[1:0] : a[1:0] + j[1:0]};
    endfunction

    // one burst of n beats; h is the beat before which the clock is frozen
    task bst(input w, input [17:0] a, input integer n, input [35:0] d,
             input [3:0] m, input integer h);
        integer i;
        reg [17:0] ad;
        reg [3:0] mm;
        reg [35:0] mk;
        begin
            for (i = 0; i < n + 2; i = i + 1) begin
                @(posedge clk);
                if (i == h) begin
                    qualN <= 1'b1;
                    repeat (2) @(posedge clk);
                end
                qualN <= 1'b0;
                loadN <= i > 0 && i < n;
                sel <= i == 0;
                wrN <= (i == 0) ? !w : w;
                addr <= (i == 0) ? a : ~a;
                mm = m & i[3:0];
                hostDrive <= w && i >= 1 && i <= n;
                hostData <= d + i;
                laneN <= mm;
                if (w && i >= 1 && i <= n) begin
                    ad = bAddr(a, i - 1);
                    mk = {{9{!mm[3]}}, {9{!mm[2]}}, {9{!mm[1]}}, {9{!mm[0]}}};
                    mem[ad[7:0]] = (mem[ad[7:0]] & ~mk) | ((d + i) & mk);
                end
                #1;
                if (i >= 1 && i <= n) begin
                    ad = bAddr(a, i - 1);
                    if (!w)
                        check(dOut, mem[ad[7:0]]);
                    check(dOeN, w || oeN || i == 1);
                end
                if (i == n + 1)
                    check(dOeN, 1'b1);
            end
        end
    endtask

    task pop(input [35:0] exp);
        integer t;
        begin
            for (t = 0; t < 20 && rValid !== 1'b1; t = t + 1)
                @(posedge clk);
            #1;
            check(rWord, exp);
            @(posedge clk) rdy <= 1'b1;
            @(posedge clk) rdy <= 1'b0;
            #1;
        end
    endtask

    task waitSlp(input v);
        integer t;
        begin
            for (t = 0; t < 10 && slp !== v; t = t + 1)
                @(posedge clk);
            #1;
            check(slp, v);
        end
    endtask

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (!sys_rst)
            check(clash, 1'b0);
        if (cycles > 2000) begin
            errorCnt = errorCnt + 1;
            close_out;
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check({dOeN, rValid, slp}, 3'h4);
        bst(1, 18'h155a2, 4, 36'h0a1b2c3d4, 4'h0, 9);
        @(posedge clk) order <= 1'b1;
        bst(1, 18'h155a1, 4, 36'h987654321, 4'h5, 9);
        bst(0, 18'h155a3, 4, 36'h0, 4'h0, 2);
        @(posedge clk) order <= 1'b0;
        bst(0, 18'h155a2, 4, 36'h0, 4'h0, 9);
        @(posedge clk) oeN <= 1'b1;
        bst(0, 18'h155a0, 2, 36'h0, 4'h0, 9);
        @(posedge clk) begin
            oeN <= 1'b0;
            rdy <= 1'b0;
        end
        bst(0, 18'h155a1, 4, 36'h0, 4'h0, 9);
        check(stall, 1'b1);
        pop(mem[8'ha1]);
        pop(mem[8'ha2]);
        pop(mem[8'ha3]);
        check(rValid, 1'b0);
        check(stall, 1'b0);
        @(posedge clk) begin
            rdy <= 1'b1;
            sleepReq <= 1'b1;
        end
        waitSlp(1'b1);
        repeat (6) @(posedge clk);
        sleepReq <= 1'b0;
        waitSlp(1'b0);
        repeat (2) @(posedge clk);
        bst(0, 18'h155a3, 2, 36'h0, 4'h0, 9);
        close_out;
    end
endmodule // flow_through_burst_sram_bench
`default_nettype wire
